// ---- hdl/spindle_clv_servo_control.sv ----
// Functional notes
// [R1] kick: phase drive high, velocity floats, filter low, motor on.
// [R2] brake: phase drive low, velocity floats, filter low, motor on.
// [R3] speed: max sync width <=21T low, 22T float, >=23T high.
// [R4] speed: gain bit low attenuates phase drive by 12 dB.
// [R5] speed: velocity floats, filter low, motor on.
// [R6] peak-hold clock is read frame clock /4, or /2 when rate bit set.
// [R7] bottom-hold clock is read frame clock /32, or /16 when bit set.
// [R8] phase: compare efm/4 with read base, or read base with write base.
// [R9] phase: filter select floats, motor on.
// [R10] phase: velocity high (high time - 278T)*32 from frame clock fall.
// [R11] auto: sample sync good every 16 frames; 8 lows select speed.
// [R12] auto: control register rates and gain apply per sub-mode.
// [R13] auto, locked: filter floats, velocity as in phase mode.
// [R14] auto, unlocked: filter low, velocity floats.
// [R15] mode command at address 1110 selects the spindle mode.
// [R16] stop: phase low, velocity floats, filter low, motor off.
// [R17] lock held 127 frames after sync good falls; code holds 254 at double speed with lock count select low.
// [R18] alternate auto: as auto at 0 dB, else guarded by sync good.
// [R19] each mode has its own code; stop after reset.
`timescale 1ns/1ps
`default_nettype none
module spindle_clv_servo_control (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic MCK,
    input wire logic MDT,
    input wire logic MLT_N,
    input wire logic EFM_NRZ,
    input wire logic RECOVERED_BIT_CLOCK,
    input wire logic READ_FRAME_CLOCK,
    input wire logic CRYSTAL_FRAME_CLOCK,
    input wire logic EFM_FRAME_CLOCK,
    input wire logic WRITE_BASE_FRAME_CLOCK,
    input wire logic WRITE_FRAME_CLOCK,
    input wire logic FRAME_SYNC_GOOD,
    input wire logic AUDIO_MUTE,
    output logic SPINDLE_PHASE_DRIVE_O,
    output logic SPINDLE_PHASE_DRIVE_OE,
    output logic SPINDLE_VELOCITY_DRIVE_O,
    output logic SPINDLE_VELOCITY_DRIVE_OE,
    output logic SPINDLE_FILTER_SELECT_O,
    output logic SPINDLE_FILTER_SELECT_OE,
    output logic SPINDLE_MOTOR_ON,
    output logic SERVO_STATE_SENSE_N_O,
    output logic SERVO_STATE_SENSE_N_OE,
    output logic LOCK_STATUS
);
    import clv_servo_pkg::*;

    localparam int NDIV = 5;
    logic [NDIV-1:0] div_src, div_tick;
    logic [DIV_W-1:0] div_m1 [NDIV];
    logic peak_tick, bottom_tick, efm_base_tick, read_base_tick, gfs_tick;

    // command registers
    logic mck_reg, mlt_reg, mck_next, mlt_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] addr_reg, addr_next;
    logic [3:0] data_ctrl_reg, data_ctrl_next, sync_att_reg, sync_att_next;
    logic [3:0] servo_ctrl_reg, servo_ctrl_next, dbl_reg, dbl_next;
    mode_t mode_reg, mode_next;
    logic cmd_latch;

    // measurement and loop state
    logic bit_reg, bit_next, efm_reg, efm_next, write_frame_clock_reg, write_frame_clock_next;
    logic write_base_frame_clock_reg, write_base_frame_clock_next;
    logic bit_rise, efm_edge, write_frame_clock_rise, write_frame_clock_fall;
    logic [RUN_W-1:0] run_reg, run_next, max_reg, max_next;
    logic [RUN_W-1:0] held_reg, held_next;
    logic [1:0] att_reg, att_next;
    logic [HW_W-1:0] hw_reg, hw_next;
    logic [VEL_W-1:0] vel_reg, vel_next;
    logic up_reg, up_next, dn_reg, dn_next;
    logic [3:0] low_reg, low_next;
    logic auto_speed_reg, auto_speed_next;
    logic [7:0] lock_reg, lock_next;
    logic lock_now, guard, zero_db;
    logic spd_o, spd_oe, pha_o, pha_oe, pd_o, pd_oe;
    logic vd_o, vd_oe, fs_o, fs_oe, on_o, sn_o, sn_oe;

    assign div_src = {WRITE_FRAME_CLOCK, CRYSTAL_FRAME_CLOCK, EFM_FRAME_CLOCK,
        READ_FRAME_CLOCK, READ_FRAME_CLOCK};
    always_comb begin
        div_m1[0] = servo_ctrl_reg[BIT_PEAK_RATE] ? DIV2_M1 : DIV4_M1; // [R6] [R12]
        div_m1[1] = servo_ctrl_reg[BIT_BOTTOM_RATE] ? DIV16_M1 : DIV32_M1; // [R7]
        div_m1[2] = DIV4_M1; // [R8]
        div_m1[3] = DIV4_M1; // [R8]
        div_m1[4] = DIV16_M1; // [R11]
    end

    generate
        for (genvar i = 0; i < NDIV; i++) begin : g_div
            clock_edge_divider #(.W(DIV_W)) u_div (
                .clk(CLK),
                .rstn(RSTN),
                .src(div_src[i]),
                .div_m1(div_m1[i]),
                .tick(div_tick[i])
            );
        end
    endgenerate
    assign peak_tick = div_tick[0];
    assign bottom_tick = div_tick[1];
    assign efm_base_tick = div_tick[2];
    assign read_base_tick = div_tick[3];
    assign gfs_tick = div_tick[4];

    // serial command port: shift on clock rise, latch on latch-strobe rise
    always_comb begin
        mck_next = MCK;
        mlt_next = MLT_N;
        shift_next = shift_reg;
        addr_next = addr_reg;
        data_ctrl_next = data_ctrl_reg;
        sync_att_next = sync_att_reg;
        servo_ctrl_next = servo_ctrl_reg;
        dbl_next = dbl_reg;
        mode_next = mode_reg;
        cmd_latch = MLT_N & ~mlt_reg;
        if (MCK && !mck_reg) begin
            shift_next = {shift_reg[6:0], MDT};
        end
        if (cmd_latch) begin
            addr_next = shift_reg[7:4];
            case (shift_reg[7:4])
                ADDR_DATA_CTRL: data_ctrl_next = shift_reg[3:0];
                ADDR_SYNC_ATTEN: sync_att_next = shift_reg[3:0];
                ADDR_SERVO_CTRL: servo_ctrl_next = shift_reg[3:0];
                ADDR_SPINDLE_MODE: mode_next = mode_t'(shift_reg[3:0]); // [R15]
                ADDR_DOUBLE_SPEED: dbl_next = shift_reg[3:0];
                default: addr_next = shift_reg[7:4];
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            mck_reg <= 1'b1; // idle high, no false shift after reset
            mlt_reg <= 1'b1;
            shift_reg <= 8'h00;
            addr_reg <= CMD_RESET;
            data_ctrl_reg <= CMD_RESET;
            sync_att_reg <= CMD_RESET;
            servo_ctrl_reg <= CMD_RESET;
            dbl_reg <= CMD_RESET;
            mode_reg <= MODE_STOP; // [R19]
        end else begin
            mck_reg <= mck_next;
            mlt_reg <= mlt_next;
            shift_reg <= shift_next;
            addr_reg <= addr_next;
            data_ctrl_reg <= data_ctrl_next;
            sync_att_reg <= sync_att_next;
            servo_ctrl_reg <= servo_ctrl_next;
            dbl_reg <= dbl_next;
            mode_reg <= mode_next;
        end
    end

    // measurement, phase detector, auto sequencing, lock
    always_comb begin
        bit_next = RECOVERED_BIT_CLOCK;
        efm_next = EFM_NRZ;
        write_frame_clock_next = WRITE_FRAME_CLOCK;
        write_base_frame_clock_next = WRITE_BASE_FRAME_CLOCK;
        bit_rise = RECOVERED_BIT_CLOCK & ~bit_reg;
        efm_edge = EFM_NRZ ^ efm_reg;
        write_frame_clock_rise = WRITE_FRAME_CLOCK & ~write_frame_clock_reg;
        write_frame_clock_fall = ~WRITE_FRAME_CLOCK & write_frame_clock_reg;
        run_next = run_reg;
        max_next = max_reg;
        held_next = held_reg;
        att_next = att_reg;
        hw_next = hw_reg;
        vel_next = vel_reg;
        if (bit_rise && run_reg != '1) begin
            run_next = run_reg + 1'b1;
        end
        if (efm_edge) begin
            run_next = '0;
            if (run_reg > max_reg) begin
                max_next = run_reg; // [R3]
            end
        end
        if (bottom_tick) begin
            held_next = max_reg; // [R7]
            max_next = '0;
        end else if (peak_tick) begin
            held_next = (max_reg > held_reg) ? max_reg : held_reg; // [R6]
            max_next = '0;
        end
        if (bit_rise) begin
            att_next = att_reg + 1'b1;
        end
        if (write_frame_clock_rise) begin
            hw_next = '0;
        end else if (WRITE_FRAME_CLOCK && bit_rise && hw_reg != '1) begin
            hw_next = hw_reg + 1'b1;
        end
        if (write_frame_clock_fall) begin
            vel_next = (hw_reg > VEL_OFFSET_T) ? // [R10]
                VEL_W'({6'h00, hw_reg - VEL_OFFSET_T} << VEL_SCALE_SHIFT) : '0;
        end else if (bit_rise && vel_reg != '0) begin
            vel_next = vel_reg - 1'b1;
        end
        // reference leads: accelerate; compared leads: decelerate
        up_next = up_reg | read_base_tick; // [R8]
        dn_next = dn_reg | (data_ctrl_reg[BIT_PHASE_REF_SEL] ?
            (WRITE_BASE_FRAME_CLOCK & ~write_base_frame_clock_reg) : efm_base_tick);
        if (up_next && dn_next) begin
            up_next = 1'b0;
            dn_next = 1'b0;
        end
        low_next = low_reg;
        auto_speed_next = auto_speed_reg;
        if (gfs_tick) begin
            if (FRAME_SYNC_GOOD) begin
                low_next = '0;
                auto_speed_next = 1'b0; // [R11]
            end else if (low_reg < GFS_LOW_SAMPLES - 4'h1) begin
                low_next = low_reg + 1'b1;
            end else begin
                low_next = GFS_LOW_SAMPLES;
                auto_speed_next = 1'b1; // [R11]
            end
        end
        lock_next = lock_reg;
        if (FRAME_SYNC_GOOD) begin
            lock_next = (dbl_reg[BIT_DOUBLE] && !dbl_reg[BIT_LOCK_CNT_SEL]) ?
                LOCK_FRAMES_DBL : LOCK_FRAMES; // [R17]
        end else if (write_frame_clock_rise && lock_reg != '0) begin
            lock_next = lock_reg - 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            bit_reg <= 1'b0;
            efm_reg <= 1'b0;
            write_frame_clock_reg <= 1'b0;
            write_base_frame_clock_reg <= 1'b0;
            run_reg <= '0;
            max_reg <= '0;
            held_reg <= '0;
            att_reg <= '0;
            hw_reg <= '0;
            vel_reg <= '0;
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
            low_reg <= '0;
            auto_speed_reg <= 1'b0;
            lock_reg <= '0;
        end else begin
            bit_reg <= bit_next;
            efm_reg <= efm_next;
            write_frame_clock_reg <= write_frame_clock_next;
            write_base_frame_clock_reg <= write_base_frame_clock_next;
            run_reg <= run_next;
            max_reg <= max_next;
            held_reg <= held_next;
            att_reg <= att_next;
            hw_reg <= hw_next;
            vel_reg <= vel_next;
            up_reg <= up_next;
            dn_reg <= dn_next;
            low_reg <= low_next;
            auto_speed_reg <= auto_speed_next;
            lock_reg <= lock_next;
        end
    end

    // output selection
    always_comb begin
        lock_now = FRAME_SYNC_GOOD | (lock_reg != '0);
        zero_db = ~sync_att_reg[BIT_ATTEN_EN] & ~AUDIO_MUTE;
        spd_o = held_reg >= SYNC_LONG_T; // [R3]
        spd_oe = held_reg != SYNC_NOMINAL_T; // [R3]
        if (!servo_ctrl_reg[BIT_GAIN] && att_reg != 2'b00) begin
            spd_oe = 1'b0; // quarter duty for -12 dB [R4] [R12]
        end
        pha_o = up_reg; // [R8]
        pha_oe = up_reg ^ dn_reg;
        pd_o = 1'b0;
        pd_oe = 1'b1;
        vd_o = 1'b0;
        vd_oe = 1'b0;
        fs_o = 1'b0;
        fs_oe = 1'b1;
        on_o = 1'b1;
        guard = 1'b0;
        case (mode_reg)
            MODE_KICK: pd_o = 1'b1; // [R1]
            MODE_BRAKE: pd_o = 1'b0; // [R2]
            MODE_SPEED: begin
                pd_o = spd_o; // [R5]
                pd_oe = spd_oe;
            end
            MODE_PHASE: begin
                pd_o = pha_o;
                pd_oe = pha_oe;
                fs_oe = 1'b0; // [R9]
                vd_o = vel_reg != '0; // [R10]
                vd_oe = 1'b1;
            end
            MODE_AUTO, MODE_ALT_AUTO: begin
                pd_o = auto_speed_reg ? spd_o : pha_o; // [R11]
                pd_oe = auto_speed_reg ? spd_oe : pha_oe;
                guard = (mode_reg == MODE_AUTO || zero_db) ? // [R18]
                    lock_now : FRAME_SYNC_GOOD;
                if (guard) begin // [R14] unguarded keeps filter low
                    fs_oe = 1'b0; // [R13]
                    vd_o = vel_reg != '0;
                    vd_oe = 1'b1;
                end
            end
            default: on_o = 1'b0; // [R16]
        endcase
        sn_o = ~(held_reg >= SENSE_WIDTH_T);
        sn_oe = addr_reg == ADDR_SPINDLE_MODE;
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            SPINDLE_PHASE_DRIVE_O <= 1'b0;
            SPINDLE_PHASE_DRIVE_OE <= 1'b1;
            SPINDLE_VELOCITY_DRIVE_O <= 1'b0;
            SPINDLE_VELOCITY_DRIVE_OE <= 1'b0;
            SPINDLE_FILTER_SELECT_O <= 1'b0;
            SPINDLE_FILTER_SELECT_OE <= 1'b1;
            SPINDLE_MOTOR_ON <= 1'b0;
            SERVO_STATE_SENSE_N_O <= 1'b1;
            SERVO_STATE_SENSE_N_OE <= 1'b0;
            LOCK_STATUS <= 1'b0;
        end else begin
            SPINDLE_PHASE_DRIVE_O <= pd_o;
            SPINDLE_PHASE_DRIVE_OE <= pd_oe;
            SPINDLE_VELOCITY_DRIVE_O <= vd_o;
            SPINDLE_VELOCITY_DRIVE_OE <= vd_oe;
            SPINDLE_FILTER_SELECT_O <= fs_o;
            SPINDLE_FILTER_SELECT_OE <= fs_oe;
            SPINDLE_MOTOR_ON <= on_o;
            SERVO_STATE_SENSE_N_O <= sn_o;
            SERVO_STATE_SENSE_N_OE <= sn_oe;
            LOCK_STATUS <= lock_now;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    chk_stop_outputs: assert property ( // [R16]
        mode_reg == MODE_STOP |=> !SPINDLE_MOTOR_ON && SPINDLE_PHASE_DRIVE_OE
            && !SPINDLE_PHASE_DRIVE_O && !SPINDLE_VELOCITY_DRIVE_OE)
        else $error("stop mode outputs wrong");
    chk_kick_drive: assert property ( // [R1]
        mode_reg == MODE_KICK |=> SPINDLE_PHASE_DRIVE_O && SPINDLE_MOTOR_ON
            && SPINDLE_FILTER_SELECT_OE && !SPINDLE_FILTER_SELECT_O)
        else $error("kick mode outputs wrong");
    chk_brake_drive: assert property ( // [R2]
        mode_reg == MODE_BRAKE |=> !SPINDLE_PHASE_DRIVE_O
            && SPINDLE_PHASE_DRIVE_OE && !SPINDLE_VELOCITY_DRIVE_OE)
        else $error("brake mode outputs wrong");
    chk_speed_window: assert property ( // [R3]
        mode_reg == MODE_SPEED && servo_ctrl_reg[BIT_GAIN]
            && held_reg == SYNC_SHORT_T |=> SPINDLE_PHASE_DRIVE_OE
            && !SPINDLE_PHASE_DRIVE_O)
        else $error("short sync width not driven low");
    chk_phase_filter: assert property ( // [R9]
        mode_reg == MODE_PHASE |=> !SPINDLE_FILTER_SELECT_OE
            && SPINDLE_MOTOR_ON && SPINDLE_VELOCITY_DRIVE_OE)
        else $error("phase mode filter or motor wrong");
    chk_lock_hold: assert property ( // [R17]
        $fell(FRAME_SYNC_GOOD) |-> lock_reg >= LOCK_FRAMES ##1 LOCK_STATUS)
        else $error("lock dropped at sync loss");
    chk_auto_unlock: assert property ( // [R14]
        mode_reg == MODE_AUTO && !lock_now |=> SPINDLE_FILTER_SELECT_OE
            && !SPINDLE_FILTER_SELECT_O && !SPINDLE_VELOCITY_DRIVE_OE)
        else $error("auto unlocked outputs wrong");
    chk_vel_width: assert property ( // [R10]
        write_frame_clock_fall && hw_reg <= VEL_OFFSET_T |=> vel_reg == '0)
        else $error("velocity pulse for short high time");
    chk_auto_speed: assert property ( // [R11]
        gfs_tick && !FRAME_SYNC_GOOD && low_reg == 4'h7 |=> auto_speed_reg)
        else $error("no speed switch after eight lows");
    chk_mode_write: assert property ( // [R15]
        cmd_latch && shift_reg[7:4] == ADDR_SPINDLE_MODE
            |=> mode_reg == $past(shift_reg[3:0]))
        else $error("mode command not applied");
endmodule // spindle_clv_servo_control
`default_nettype wire

// ---- hdl/clv_servo_pkg.sv ----
package clv_servo_pkg;
    localparam logic [3:0] ADDR_DATA_CTRL = 4'h9;
    localparam logic [3:0] ADDR_SYNC_ATTEN = 4'hA;
    localparam logic [3:0] ADDR_SERVO_CTRL = 4'hD;
    localparam logic [3:0] ADDR_SPINDLE_MODE = 4'hE;
    localparam logic [3:0] ADDR_DOUBLE_SPEED = 4'hF;
    localparam int BIT_PHASE_REF_SEL = 1;
    localparam int BIT_ATTEN_EN = 0;
    localparam int BIT_GAIN = 0;
    localparam int BIT_PEAK_RATE = 1;
    localparam int BIT_BOTTOM_RATE = 2;
    localparam int BIT_DOUBLE = 0;
    localparam int BIT_LOCK_CNT_SEL = 2;
    localparam logic [3:0] CMD_RESET = 4'h0;
    localparam int RUN_W = 8;
    localparam logic [7:0] SYNC_SHORT_T = 8'h15;
    localparam logic [7:0] SYNC_NOMINAL_T = 8'h16;
    localparam logic [7:0] SYNC_LONG_T = 8'h17;
    localparam logic [7:0] SENSE_WIDTH_T = 8'h40;
    localparam int HW_W = 10;
    localparam logic [9:0] VEL_OFFSET_T = 10'h116;
    localparam int VEL_SCALE_SHIFT = 5;
    localparam int VEL_W = 16;
    localparam logic [3:0] GFS_LOW_SAMPLES = 4'h8;
    localparam logic [7:0] LOCK_FRAMES = 8'h7F;
    localparam logic [7:0] LOCK_FRAMES_DBL = 8'hFE;
    localparam int DIV_W = 5;
    localparam logic [4:0] DIV4_M1 = 5'h03;
    localparam logic [4:0] DIV2_M1 = 5'h01;
    localparam logic [4:0] DIV32_M1 = 5'h1F;
    localparam logic [4:0] DIV16_M1 = 5'h0F;
    typedef enum logic [3:0] {
        MODE_STOP = 4'b0000,
        MODE_KICK = 4'b1000,
        MODE_BRAKE = 4'b1010,
        MODE_SPEED = 4'b1110,
        MODE_PHASE = 4'b1111,
        MODE_AUTO = 4'b0110,
        MODE_ALT_AUTO = 4'b0101
    } mode_t;
endpackage

// ---- hdl/clock_edge_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_edge_divider #(
    parameter int W = 5
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic src,
    input wire logic [W-1:0] div_m1,
    output logic tick
);
    logic src_reg, src_next;
    logic [W-1:0] cnt_reg, cnt_next;
    logic rise;

    always_comb begin
        rise = src & ~src_reg;
        src_next = src;
        cnt_next = cnt_reg;
        tick = 1'b0;
        if (rise) begin
            if (cnt_reg >= div_m1) begin
                cnt_next = '0;
                tick = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            src_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            src_reg <= src_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule // clock_edge_divider
`default_nettype wire

// ---- bench/spindle_motor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spindle_motor_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic phase_o,
    input wire logic phase_oe,
    input wire logic motor_on,
    output var int speed
);
    // loop filter holds its charge while the phase pin floats
    always_ff @(posedge clk) begin
        if (!rstn) begin
            speed <= 0;
        end else if (motor_on && phase_oe) begin
            speed <= phase_o ? speed + 1 : speed - 1;
        end
    end
endmodule // spindle_motor_model
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module tb;
    import clv_servo_pkg::*;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic mck = 1'h1;
    logic mdt = 1'h0;
    logic mlt_n = 1'h1;
    logic efm_nrz = 1'h0;
    logic bit_clk = 1'h0;
    logic read_frame_clock = 1'h0;
    logic xfck = 1'h0;
    logic efck = 1'h0;
    logic write_base_frame_clock = 1'h0;
    logic write_frame_clock = 1'h0;
    logic frame_sync_good = 1'h0;
    logic mute = 1'h0;
    logic pd_o, pd_oe, vd_o, vd_oe, fs_o, fs_oe, motor_on, lock;
    logic sense_n_o, sense_n_oe;
    logic bc_en = 1'h0;
    logic [1:0] bc_cnt = 2'h0;
    int efm_run = 0;
    int t_cnt = 0;
    int motor_speed;
    int failures = 0;
    int cmp_count = 0;

    spindle_clv_servo_control spindle_clv_servo_control_i (
        .CLK(clk), .RSTN(rstn), .MCK(mck), .MDT(mdt), .MLT_N(mlt_n),
        .EFM_NRZ(efm_nrz), .RECOVERED_BIT_CLOCK(bit_clk),
        .READ_FRAME_CLOCK(read_frame_clock), .CRYSTAL_FRAME_CLOCK(xfck),
        .EFM_FRAME_CLOCK(efck), .WRITE_BASE_FRAME_CLOCK(write_base_frame_clock),
        .WRITE_FRAME_CLOCK(write_frame_clock), .FRAME_SYNC_GOOD(frame_sync_good), .AUDIO_MUTE(mute),
        .SPINDLE_PHASE_DRIVE_O(pd_o), .SPINDLE_PHASE_DRIVE_OE(pd_oe),
        .SPINDLE_VELOCITY_DRIVE_O(vd_o), .SPINDLE_VELOCITY_DRIVE_OE(vd_oe),
        .SPINDLE_FILTER_SELECT_O(fs_o), .SPINDLE_FILTER_SELECT_OE(fs_oe),
        .SPINDLE_MOTOR_ON(motor_on), .SERVO_STATE_SENSE_N_O(sense_n_o),
        .SERVO_STATE_SENSE_N_OE(sense_n_oe), .LOCK_STATUS(lock)
    );

    spindle_motor_model spindle_motor_model_i (
        .clk(clk), .rstn(rstn), .phase_o(pd_o), .phase_oe(pd_oe),
        .motor_on(motor_on), .speed(motor_speed)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    // bit clock of four system cycles; efm edges land on its falls
    always @(posedge clk) begin
        if (bc_en) begin
            bc_cnt <= bc_cnt + 2'h1;
            bit_clk <= bc_cnt[1];
            if (bc_cnt == 2'h0 && efm_run != 0) begin
                if (t_cnt >= efm_run - 1) begin
                    efm_nrz <= ~efm_nrz;
                    t_cnt <= 0;
                end else begin
                    t_cnt <= t_cnt + 1;
                end
            end
        end
    end

    function automatic logic [5:0] pins();
        return {pd_o & pd_oe, pd_oe, vd_oe, fs_o & fs_oe, fs_oe, motor_on};
    endfunction

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic send(input logic [3:0] a, input logic [3:0] d);
        logic [7:0] b;
        b = {a, d};
        @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            mdt <= b[i];
            mck <= 1'h0;
            repeat (2) @(posedge clk);
            mck <= 1'h1;
            repeat (2) @(posedge clk);
        end
        mlt_n <= 1'h0;
        repeat (2) @(posedge clk);
        mlt_n <= 1'h1;
        cycles(4);
    endtask

    // which: 0 read frame, 1 crystal frame, 3 efm frame, else write base
    task automatic pulse(input int which, input int n);
        repeat (n) begin
            @(posedge clk);
            case (which)
                0: read_frame_clock <= 1'h1;
                1: xfck <= 1'h1;
                3: efck <= 1'h1;
                default: write_base_frame_clock <= 1'h1;
            endcase
            repeat (3) @(posedge clk);
            {read_frame_clock, xfck, write_base_frame_clock, efck} <= 4'h0;
            repeat (3) @(posedge clk);
        end
        #1;
    endtask

    task automatic frames(input int n, input int hi);
        repeat (n) begin
            @(posedge clk);
            write_frame_clock <= 1'h1;
            repeat (hi) @(posedge clk);
            write_frame_clock <= 1'h0;
            repeat (8) @(posedge clk);
        end
        #1;
    endtask

    task automatic t_direct();
        logic [3:0] code [3] = '{MODE_KICK, MODE_BRAKE, MODE_STOP};
        logic [5:0] exp [3] = '{6'h33, 6'h13, 6'h12};
        for (int i = 0; i < 3; i++) begin
            send(ADDR_SPINDLE_MODE, code[i]);
            `CHECK("direct_pins", exp[i], pins());
            `CHECK("sense_on", 2'h3, {sense_n_o, sense_n_oe});
            if (i == 0) `CHECK("motor_accel", 1'h1, motor_speed > 0);
        end
        send(4'h3, MODE_KICK);
        `CHECK("foreign_addr", 6'h12, pins());
        `CHECK("sense_off", 1'h0, sense_n_oe);
    endtask

    task automatic t_speed();
        int w [4] = '{21, 22, 23, 21};
        logic [5:0] exp [4] = '{6'h13, 6'h03, 6'h33, 6'h13};
        int n;
        int bad;
        @(posedge clk);
        bc_en <= 1'h1;
        efm_run <= w[0];
        // bottom hold /16 releases at pulse 48, /32 would not
        send(ADDR_SERVO_CTRL, 4'h7);
        send(ADDR_SPINDLE_MODE, MODE_SPEED);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            efm_run <= w[i];
            repeat (13) begin
                cycles(200);
                pulse(0, 1);
            end
            `CHECK("speed_pins", exp[i], pins());
        end
        send(ADDR_SERVO_CTRL, 4'h2);
        n = 0;
        bad = 0;
        repeat (64) begin
            cycles(1);
            if (pd_oe === 1'h1) begin
                n++;
                if (pd_o !== 1'h0) bad++;
            end
        end
        `CHECK("atten_duty", 16, n);
        `CHECK("atten_level", 0, bad);
        @(posedge clk);
        efm_run <= 0;
    endtask

    task automatic t_phase();
        int n;
        send(ADDR_DATA_CTRL, 4'h0);
        send(ADDR_SPINDLE_MODE, MODE_PHASE);
        `CHECK("phase_filter", 2'h1, {fs_oe, motor_on});
        pulse(1, 5);
        `CHECK("phase_up", 2'h3, {pd_o, pd_oe});
        pulse(3, 4);
        `CHECK("phase_efm_clear", 1'h0, pd_oe);
        pulse(1, 3);
        send(ADDR_DATA_CTRL, 4'h2);
        pulse(2, 1);
        `CHECK("phase_clear", 1'h0, pd_oe);
        pulse(2, 1);
        `CHECK("phase_down", 2'h1, {pd_o, pd_oe});
        // keep frame edges clear of bit clock rises
        do @(posedge clk); while (bc_cnt != 2'h0);
        write_frame_clock <= 1'h1;
        repeat (1120) @(posedge clk);
        write_frame_clock <= 1'h0;
        n = 0;
        repeat (400) begin
            cycles(1);
            if (vd_o === 1'h1 && vd_oe === 1'h1) n++;
        end
        `CHECK("velocity_t", 64, (n + 2) / 4);
        `CHECK("velocity_low", 2'h1, {vd_o, vd_oe});
    endtask

    task automatic t_lock();
        int n;
        @(posedge clk);
        bc_en <= 1'h0;
        send(ADDR_SPINDLE_MODE, MODE_AUTO);
        @(posedge clk);
        frame_sync_good <= 1'h1;
        frames(20, 4);
        `CHECK("auto_locked", 2'h2, {lock, fs_oe});
        @(posedge clk);
        frame_sync_good <= 1'h0;
        n = 0;
        while (lock === 1'h1 && n < 200) begin
            frames(1, 4);
            n++;
        end
        `CHECK("lock_frames", 127, n);
        `CHECK("auto_unlocked", 3'h2, {fs_o, fs_oe, vd_oe});
    endtask

    task automatic t_alt();
        send(ADDR_SPINDLE_MODE, MODE_ALT_AUTO);
        @(posedge clk);
        mute <= 1'h1;
        frame_sync_good <= 1'h1;
        cycles(4);
        `CHECK("alt_sync_good", 1'h0, fs_oe);
        @(posedge clk);
        frame_sync_good <= 1'h0;
        cycles(4);
        `CHECK("alt_sync_lost", 3'h2, {fs_o, fs_oe, vd_oe});
        @(posedge clk);
        mute <= 1'h0;
        cycles(4);
        `CHECK("alt_zero_db", 1'h0, fs_oe);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        $display("mismatch watchdog expected done seen timeout");
        conclude();
    end

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'h1;
        cycles(2);
        `CHECK("reset_pins", 7'h24, {pins(), lock});
        t_direct();
        t_speed();
        t_phase();
        t_lock();
        t_alt();
        conclude();
    end
endmodule // tb
`default_nettype wire
